// ===== pkg/tpr_map.vh
// register map, field positions, reset values and codes for the
// triggered pwm block; included by the core files, definitions only.
// What this block does
// - edge select: two 2-bit fields, upper zero
// - period equals period compare plus one
// - channel width equals its compare value
// - reload only armed by channel 1 write
// - armed reload copies all four at clear
// - colliding write: shadow copies the old value
// - behaviour active only in mode code 010
// - wait at ffff, trigger clears, retrigger restarts
// - period irq on period equality, not on trigger clear, channel irq on equality
// - trigger from external edge or soft bit
`ifndef TPR_MAP_VH
`define TPR_MAP_VH

`define TPR_ADR_CTRL       8'h00
`define TPR_ADR_EDGE_SEL   8'h04
`define TPR_ADR_PERIOD     8'h08
`define TPR_ADR_CH1        8'h0c
`define TPR_ADR_CH2        8'h10
`define TPR_ADR_CH3        8'h14
`define TPR_ADR_COUNT      8'h18
`define TPR_ADR_IRQ_STAT   8'h1c
`define TPR_ADR_IRQ_MASK   8'h20

// control register fields
`define TPR_CTRL_CE_BIT    0
`define TPR_CTRL_EST_BIT   1
`define TPR_CTRL_MD_LSB    4
`define TPR_CTRL_MD_MSB    6

`define TPR_MODE_TRIG_PWM  3'h2

// edge select fields: 00 none, 01 rising, 10 falling, 11 both
`define TPR_ETS_LSB        0
`define TPR_EES_LSB        2
`define TPR_EDGE_RISE      2'h1
`define TPR_EDGE_FALL      2'h2
`define TPR_EDGE_BOTH      2'h3

// interrupt status bits
`define TPR_IRQ_PERIOD     0
`define TPR_IRQ_CH1        1
`define TPR_IRQ_CH2        2
`define TPR_IRQ_CH3        3

`define TPR_CNT_IDLE       16'hffff
`define TPR_CNT_ZERO       16'h0000
`define TPR_RST_COMPARE    16'h0000

`endif

// ===== core/tpr_edge_det.v
// selectable edge detector for one synchronous input
// assumes the input is already synchronous to i_sys_clk
`include "tpr_map.vh"
`default_nettype none
module tpr_edge_det (
  input  wire       i_sys_clk,
  input  wire       i_resetn,
  input  wire       i_sig,
  input  wire [1:0] i_sel,
  output wire       o_edge
);
  reg prev_reg;

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= i_sig;
    end
  end

  assign o_edge = ((i_sel == `TPR_EDGE_RISE) && i_sig && !prev_reg) ||
                  ((i_sel == `TPR_EDGE_FALL) && !i_sig && prev_reg) ||
                  ((i_sel == `TPR_EDGE_BOTH) && (i_sig != prev_reg));
endmodule // tpr_edge_det
`default_nettype wire

// ===== core/tpr_top.v
// triggered pwm timer with buffered compare reload, wishbone slave
// assumes classic wishbone master on i_sys_clk, synchronous pins
`include "tpr_map.vh"
`default_nettype none
module tpr_top #(
  parameter CW = 16
) (
  input  wire        i_sys_clk,
  input  wire        i_resetn,
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [7:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  input  wire        i_ext_trigger,
  input  wire        i_ext_event,
  output reg         o_pwm_out_ch1,
  output reg         o_pwm_out_ch2,
  output reg         o_pwm_out_ch3,
  output reg         o_irq
);
  reg  [CW-1:0] compare_reg [0:3];
  reg  [CW-1:0] compare_shadow_reg [0:3];
  reg  [CW-1:0] counter_reg;
  reg  [CW-1:0] counter_next;
  reg           running_reg;
  reg           reload_armed_reg;
  reg           count_enable_bit_reg;
  reg           soft_trigger_bit_reg;
  reg  [2:0]    mode_select_reg;
  reg  [3:0]    input_edge_select_reg;
  reg  [3:0]    irq_stat_reg;
  reg  [3:0]    irq_mask_reg;
  reg  [3:0]    irq_set;
  reg  [31:0]   rd_data;
  reg           clear_now;

  wire       ext_edge;
  wire       bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire       wr_en   = bus_req && i_wb_we;
  wire       pwm_mode = count_enable_bit_reg &&
                        (mode_select_reg == `TPR_MODE_TRIG_PWM);
  wire       trigger = pwm_mode &&
                       (ext_edge || soft_trigger_bit_reg);
  wire       period_hit = running_reg &&
                          (counter_reg == compare_shadow_reg[0]);

  // event count edge field is stored but unused in this mode
  tpr_edge_det u_trig_edge (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_sig     (i_ext_trigger),
    .i_sel     (input_edge_select_reg[`TPR_ETS_LSB+1:`TPR_ETS_LSB]),
    .o_edge    (ext_edge)
  );

  function wr_hit;
    input [7:0] adr;
    begin
      wr_hit = wr_en && (i_wb_adr == adr) && (&i_wb_sel[1:0]);
    end
  endfunction

  // counter: clear on trigger or on count after period equality
  always @* begin
    clear_now    = 1'b0;
    counter_next = counter_reg;
    if (!pwm_mode) begin
      counter_next = `TPR_CNT_IDLE;
    end else if (trigger || period_hit) begin
      clear_now    = 1'b1;
      counter_next = `TPR_CNT_ZERO;
    end else if (running_reg) begin
      counter_next = counter_reg + 16'h0001;
    end
  end

  integer k;
  always @* begin
    irq_set = 4'h0;
    irq_set[`TPR_IRQ_PERIOD] = period_hit && !trigger;
    for (k = 1; k < 4; k = k + 1) begin
      // trigger in the same cycle suppresses the channel match
      irq_set[k] = running_reg && !trigger &&
                   (counter_reg == compare_shadow_reg[k]);
    end
  end

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      counter_reg <= `TPR_CNT_IDLE;
      running_reg <= 1'b0;
    end else begin
      counter_reg <= counter_next;
      if (!pwm_mode) begin
        running_reg <= 1'b0;
      end else if (trigger) begin
        running_reg <= 1'b1;
      end
    end
  end

  // compare registers and their shadows
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_cmp
      // compare words sit on consecutive words from the period word
      localparam integer OFS = 4 * g;
      always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          compare_reg[g]        <= `TPR_RST_COMPARE;
          compare_shadow_reg[g] <= `TPR_RST_COMPARE;
        end else begin
          if (wr_hit(`TPR_ADR_PERIOD + OFS[7:0])) begin
            compare_reg[g] <= i_wb_dat[CW-1:0];
          end
          // colliding write lands next cycle; shadow takes old value
          if (clear_now && reload_armed_reg) begin
            compare_shadow_reg[g] <= compare_reg[g];
          end
        end
      end
    end
  endgenerate

  // only a channel 1 write arms the reload
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      reload_armed_reg <= 1'b0;
    end else if (wr_hit(`TPR_ADR_CH1)) begin
      reload_armed_reg <= 1'b1;
    end else if (clear_now) begin
      reload_armed_reg <= 1'b0;
    end
  end

  // outputs: active from clear, inactive at match
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pwm_out_ch1 <= 1'b0;
      o_pwm_out_ch2 <= 1'b0;
      o_pwm_out_ch3 <= 1'b0;
    end else if (!pwm_mode) begin
      o_pwm_out_ch1 <= 1'b0;
      o_pwm_out_ch2 <= 1'b0;
      o_pwm_out_ch3 <= 1'b0;
    end else if (clear_now) begin
      // zero compare means 0% output: never goes active
      o_pwm_out_ch1 <= (compare_shadow_reg[1] != 16'h0000);
      o_pwm_out_ch2 <= (compare_shadow_reg[2] != 16'h0000);
      o_pwm_out_ch3 <= (compare_shadow_reg[3] != 16'h0000);
    end else begin
      if (counter_next == compare_shadow_reg[1]) begin
        o_pwm_out_ch1 <= 1'b0;
      end
      if (counter_next == compare_shadow_reg[2]) begin
        o_pwm_out_ch2 <= 1'b0;
      end
      if (counter_next == compare_shadow_reg[3]) begin
        o_pwm_out_ch3 <= 1'b0;
      end
    end
  end

  // control, edge select and interrupt registers
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_enable_bit_reg  <= 1'b0;
      soft_trigger_bit_reg  <= 1'b0;
      mode_select_reg       <= 3'h0;
      input_edge_select_reg <= 4'h0;
      irq_stat_reg          <= 4'h0;
      irq_mask_reg          <= 4'h0;
      o_irq                 <= 1'b0;
    end else begin
      soft_trigger_bit_reg <= 1'b0;
      if (wr_en && i_wb_adr == `TPR_ADR_CTRL && i_wb_sel[0]) begin
        count_enable_bit_reg <= i_wb_dat[`TPR_CTRL_CE_BIT];
        soft_trigger_bit_reg <= i_wb_dat[`TPR_CTRL_EST_BIT];
        mode_select_reg <= i_wb_dat[`TPR_CTRL_MD_MSB:`TPR_CTRL_MD_LSB];
      end
      if (wr_en && i_wb_adr == `TPR_ADR_EDGE_SEL && i_wb_sel[0]) begin
        input_edge_select_reg <= i_wb_dat[3:0];
      end
      if (wr_en && i_wb_adr == `TPR_ADR_IRQ_MASK && i_wb_sel[0]) begin
        irq_mask_reg <= i_wb_dat[3:0];
      end
      // set wins over a write-one clear in the same cycle
      if (wr_en && i_wb_adr == `TPR_ADR_IRQ_STAT && i_wb_sel[0]) begin
        irq_stat_reg <= (irq_stat_reg & ~i_wb_dat[3:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      o_irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  always @* begin
    rd_data = 32'h00000000;
    case (i_wb_adr)
      `TPR_ADR_CTRL: begin
        rd_data[`TPR_CTRL_CE_BIT] = count_enable_bit_reg;
        rd_data[`TPR_CTRL_MD_MSB:`TPR_CTRL_MD_LSB] = mode_select_reg;
      end
      `TPR_ADR_EDGE_SEL: rd_data[3:0]    = input_edge_select_reg;
      `TPR_ADR_PERIOD:   rd_data[CW-1:0] = compare_reg[0];
      `TPR_ADR_CH1:      rd_data[CW-1:0] = compare_reg[1];
      `TPR_ADR_CH2:      rd_data[CW-1:0] = compare_reg[2];
      `TPR_ADR_CH3:      rd_data[CW-1:0] = compare_reg[3];
      `TPR_ADR_COUNT:    rd_data[CW-1:0] = counter_reg;
      `TPR_ADR_IRQ_STAT: rd_data[3:0]    = irq_stat_reg;
      `TPR_ADR_IRQ_MASK: rd_data[3:0]    = irq_mask_reg;
      default:           rd_data = 32'h00000000;
    endcase
  end

  // one-cycle ack; unmapped addresses ack with zero data
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= bus_req;
      o_wb_dat <= bus_req ? rd_data : 32'h00000000;
    end
  end
endmodule // tpr_top
`default_nettype wire

// ===== sim/tpr_top_assertions.sv
// checker on the tpr_top ports: bus answers and idle outputs
// assumes it is bound to every tpr_top instance, one clock domain
`default_nettype none
module tpr_top_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_resetn,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        o_pwm_out_ch1,
  input wire logic        o_pwm_out_ch2,
  input wire logic        o_pwm_out_ch3
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // run_reg mirrors ctrl so idle checks need no view of the body
  logic run_reg;
  wire logic take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire logic rd_q = take & ~i_wb_we;
  always_ff @(posedge i_sys_clk or negedge i_resetn)
    if (!i_resetn)
      run_reg <= 1'b0;
    else if (take & i_wb_we & i_wb_sel[0] & (i_wb_adr == 8'h00))
      run_reg <= i_wb_dat[0] & (i_wb_dat[6:4] == 3'h2);
  property p_ack_req; take |=> o_wb_ack; endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack missing");
  property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_ack_cause; o_wb_ack |-> $past(take); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_dat_zero; !o_wb_ack |-> o_wb_dat == 32'h0; endproperty
  a_dat_zero: assert property (p_dat_zero) else $error("data not zero");
  property p_edge_rb;
    o_wb_ack && $past(rd_q && i_wb_adr == 8'h04) |-> o_wb_dat[31:4] == 0;
  endproperty
  a_edge_rb: assert property (p_edge_rb) else $error("edge hi");
  property p_unmapped;
    o_wb_ack && $past(rd_q && i_wb_adr > 8'h20) |-> o_wb_dat == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_off_low;
    !run_reg && $past(!run_reg) |-> !(o_pwm_out_ch1 | o_pwm_out_ch2
                                      | o_pwm_out_ch3);
  endproperty
  a_off_low: assert property (p_off_low) else $error("pwm out");
  property p_cnt_idle;
    o_wb_ack && !run_reg && $past(rd_q && i_wb_adr == 8'h18 && !run_reg)
      |-> o_wb_dat[15:0] == 16'hffff;
  endproperty
  a_cnt_idle: assert property (p_cnt_idle) else $error("idle");
endmodule // tpr_top_chk
bind tpr_top tpr_top_chk u_chk (.i_sys_clk, .i_resetn, .i_wb_cyc,
  .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat,
  .o_wb_ack, .o_pwm_out_ch1, .o_pwm_out_ch2, .o_pwm_out_ch3);
`default_nettype wire

// ===== sim/triggered_pwm_reload_tb.sv
// self-checking bench for tpr_top: registers, pwm timing, reload, irq
// assumes one 40 MHz clock and pins synchronous to it
`default_nettype none
module triggered_pwm_reload_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_sys_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_wb_cyc = 1'b0;
  logic        i_wb_stb = 1'b0;
  logic        i_wb_we = 1'b0;
  logic [7:0]  i_wb_adr = 8'h00;
  logic [3:0]  i_wb_sel = 4'hf;
  logic [31:0] i_wb_dat = 32'h0;
  logic        i_ext_trigger = 1'b0;
  logic        i_ext_event = 1'b0;
  wire logic [31:0] o_wb_dat;
  wire logic   o_wb_ack, o_pwm_out_ch1, o_pwm_out_ch2, o_pwm_out_ch3, o_irq;
  int          err_total = 0;
  int          check_count = 0;
  int          n;
  logic [31:0] rd;
  always #12.5 i_sys_clk = ~i_sys_clk;
  tpr_top dut (.i_sys_clk, .i_resetn, .i_wb_cyc, .i_wb_stb, .i_wb_we,
    .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_ext_trigger,
    .i_ext_event, .o_pwm_out_ch1, .o_pwm_out_ch2, .o_pwm_out_ch3, .o_irq);
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input int d,
                    input logic [3:0] s = 4'hf);
    int k;
    @(posedge i_sys_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_sel <= s;
    i_wb_adr <= a;
    i_wb_dat <= 32'(d);
    k = 0;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (o_wb_ack !== 1'b1 && k < 50);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    if (k >= 50) begin
      err_total++;
      $display("[ERR] ack exp 1 got %b", o_wb_ack);
      finish_test();
    end
  endtask
  // waits for ch1 to reach level v; a stuck output ends the run
  task automatic wait_ch1(input logic v);
    for (n = 0; n < 99 && o_pwm_out_ch1 !== v; n++) @(posedge i_sys_clk);
    if (n >= 99) begin
      err_total++;
      $display("[ERR] ch1 level exp %b got %b", v, o_pwm_out_ch1);
      finish_test();
    end
  endtask
  // high cycles per output over one period, from ch1 rise to ch1 rise
  task automatic meas(input int e1, e2, e3, ep);
    int h1, h2, h3, p;
    logic lo;
    wait_ch1(1'b0);
    wait_ch1(1'b1);
    {h1, h2, h3, p, lo} = 0;
    while (p < 99 && !(lo && o_pwm_out_ch1 === 1'b1)) begin
      lo = lo | (o_pwm_out_ch1 === 1'b0);
      h1 += int'(o_pwm_out_ch1 === 1'b1);
      h2 += int'(o_pwm_out_ch2 === 1'b1);
      h3 += int'(o_pwm_out_ch3 === 1'b1);
      p++;
      @(posedge i_sys_clk);
    end
    chk("ch1", e1, h1);
    chk("ch2", e2, h2);
    chk("ch3", e3, h3);
    chk("period", ep, p);
  endtask
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    wb(1, 8'h04, 'hff);
    wb(0, 8'h04, 0);
    chk("edge_sel", 'h0f, rd);
    wb(0, 8'h24, 0);
    chk("unmapped", 0, rd);
    wb(0, 8'h18, 0);
    chk("count", 'hffff, rd);
    // compare words need both low byte lanes; a narrow write is dropped
    wb(1, 8'h14, 'h77, 4'h1);
    wb(0, 8'h14, 0);
    chk("sel_gate", 0, rd);
    $display("regs done");
    wb(1, 8'h04, 1);
    wb(1, 8'h08, 9);
    wb(1, 8'h10, 5);
    wb(1, 8'h14, 4);
    wb(1, 8'h0c, 3);
    wb(1, 8'h20, 1);
    wb(1, 8'h00, 'h23);
    meas(3, 5, 4, 10);
    chk("irq", 1, o_irq);
    wb(0, 8'h1c, 0);
    chk("irq_stat", 'hf, rd);
    wb(1, 8'h20, 0);
    @(posedge i_sys_clk);
    chk("irq_mask", 0, o_irq);
    wb(1, 8'h0c, 2);
    meas(2, 5, 4, 10);
    wb(1, 8'h10, 1);
    meas(2, 5, 4, 10);
    wb(1, 8'h0c, 2);
    meas(2, 1, 4, 10);
    wb(1, 8'h08, 5);
    wb(1, 8'h0c, 2);
    meas(2, 1, 4, 6);
    wb(1, 8'h10, 3);
    wb(1, 8'h14, 2);
    wb(1, 8'h0c, 1);
    meas(1, 3, 2, 6);
    $display("pwm done");
    wait_ch1(1'b0);
    i_ext_trigger <= 1'b1;
    for (n = 0; n < 9 && o_pwm_out_ch1 !== 1'b1; n++) @(posedge i_sys_clk);
    chk("retrigger", 1, n <= 3);
    // falling edge select: the release of the trigger pin restarts
    wb(1, 8'h04, 2);
    wait_ch1(1'b1);
    wait_ch1(1'b0);
    i_ext_trigger <= 1'b0;
    for (n = 0; n < 9 && o_pwm_out_ch1 !== 1'b1; n++) @(posedge i_sys_clk);
    chk("fall_trig", 1, n <= 3);
    wb(1, 8'h00, 1);
    repeat (2) @(posedge i_sys_clk);
    chk("off", 0, o_pwm_out_ch1 | o_pwm_out_ch2 | o_pwm_out_ch3);
    wb(1, 8'h1c, 'hf);
    wb(0, 8'h1c, 0);
    chk("irq_clr", 0, rd);
    $display("irq done");
    finish_test();
  end
endmodule // triggered_pwm_reload_tb
`default_nettype wire
